// >>> hw/tsa_config_regs.sv
// tuner seek, band, volume, softmute and oscillator configuration bank
`timescale 1ns/1ps
module tsa_config_regs
   import tsa_pkg::*;
#(
   parameter int CHAN_W = 10
)
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic [DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [DATA_W-1:0] reg_rdata_out,
   // tuning
   input wire logic [CHAN_W-1:0] channel_in,
   output logic [FREQ_W-1:0] tuned_freq_khz_out,
   output logic tuned_freq_valid_out,
   // seek candidate qualification
   input wire logic cand_valid_in,
   input wire logic [7:0] cand_strength_in,
   input wire logic [3:0] cand_snr_in,
   input wire logic [4:0] cand_impulses_in,
   output logic cand_accept_out,
   output logic cand_reject_out,
   // audio
   output logic audio_mute_out,
   output logic [3:0] volume_code_out,
   output logic low_volume_range_out,
   output logic [5:0] volume_atten_db_out,
   output logic [1:0] softmute_rate_out,
   output logic [4:0] softmute_depth_db_out,
   // power and oscillator pins
   input wire logic powered_down_in,
   input wire logic io_supply_ok_in,
   output logic crystal_osc_enable_out,
   output logic audio_hiz_active_out
);

   // ***************************************
   // elaboration check
   // ***************************************
   generate
      if (CHAN_W < 1 || CHAN_W > 10)
      begin : g_bad_chan
         $error("channel width must be 1 to 10");
      end
   endgenerate

   // ***************************************
   // state
   // ***************************************
   typedef struct packed {
      logic [15:0] cfg_sbv;
      logic [15:0] cfg_sq;
      logic [15:0] cfg_osc;
      logic [15:0] rdata;
      logic [FREQ_W-1:0] freq;
      logic freq_valid;
      logic accept;
      logic reject;
      logic [5:0] atten;
      logic [4:0] depth;
      logic pd_meta;
      logic pd_sync;
      logic vio_meta;
      logic vio_sync;
      logic hiz;
      logic mute;
   } tsa_state_t;

   tsa_state_t state_ff;
   tsa_state_t nxt_state;

   // read value for a register index, zero when unmapped
   function automatic logic [15:0] read_word(input logic [7:0] idx,
                                             input tsa_state_t s);
      logic [15:0] w;
      w = 16'h0000;
      case (idx)
         SEEK_BAND_VOLUME_CONFIG_IDX: w = s.cfg_sbv;
         SOFTMUTE_SEEK_QUALITY_CONFIG_IDX: w = s.cfg_sq;
         OSCILLATOR_AUDIO_HIZ_CONFIG_IDX: w = s.cfg_osc;
         default: w = 16'h0000;
      endcase
      return w;
   endfunction

   // ***************************************
   // next state
   // ***************************************
   logic [1:0] band;
   logic [1:0] step;
   logic [3:0] vol;
   logic [7:0] floor_lvl;
   logic [3:0] snr_q;
   logic [3:0] imp_q;
   logic [4:0] imp_allowed;
   logic [FREQ_W-1:0] base_khz;
   logic [7:0] step_khz;
   logic base_ok;
   logic step_ok;
   logic strength_ok;
   logic snr_ok;
   logic imp_ok;

   always_comb
   begin
      nxt_state = state_ff;
      band = state_ff.cfg_sbv[BAND_LSB +: 2];
      step = state_ff.cfg_sbv[STEP_LSB +: 2];
      vol = state_ff.cfg_sbv[VOLUME_LSB +: 4];
      floor_lvl = state_ff.cfg_sbv[SEEK_STRENGTH_FLOOR_LSB +: 8];
      snr_q = state_ff.cfg_sq[SEEK_SNR_QUALIFIER_LSB +: 4];
      imp_q = state_ff.cfg_sq[SEEK_IMPULSE_LIMIT_LSB +: 4];

      // register writes store every bit as written
      if (reg_wr_in)
      begin
         case (reg_addr_in)
            SEEK_BAND_VOLUME_CONFIG_IDX:
               nxt_state.cfg_sbv = reg_wdata_in;
            SOFTMUTE_SEEK_QUALITY_CONFIG_IDX:
               nxt_state.cfg_sq = reg_wdata_in;
            OSCILLATOR_AUDIO_HIZ_CONFIG_IDX:
               nxt_state.cfg_osc = reg_wdata_in;
            default:
               nxt_state.rdata = state_ff.rdata;
         endcase
      end
      nxt_state.rdata = reg_rd_in ? read_word(reg_addr_in, state_ff)
                                  : 16'h0000;
      // mute flag follows the stored volume code in the same cycle
      nxt_state.mute = (nxt_state.cfg_sbv[VOLUME_LSB +: 4]
                       == 4'h0);

      // band base and channel step
      base_ok = 1'b1;
      case (band)
         BAND_WIDE_EU: base_khz = BASE_87M5_KHZ;
         BAND_WIDE_JP: base_khz = BASE_76M_KHZ;
         BAND_NARROW_JP: base_khz = BASE_76M_KHZ;
         default:
         begin
            base_khz = BASE_87M5_KHZ;
            base_ok = 1'b0;
         end
      endcase
      step_ok = 1'b1;
      case (step)
         STEP_200K: step_khz = STEP_200_KHZ;
         STEP_100K: step_khz = STEP_100_KHZ;
         STEP_50K: step_khz = STEP_50_KHZ;
         default:
         begin
            step_khz = STEP_200_KHZ;
            step_ok = 1'b0;
         end
      endcase
      nxt_state.freq = base_khz + FREQ_W'(FREQ_W'(step_khz)
                       * FREQ_W'(channel_in));
      nxt_state.freq_valid = base_ok && step_ok;

      // seek qualification of a candidate channel
      strength_ok = cand_strength_in >= floor_lvl;
      snr_ok = (snr_q == 4'h0) || (cand_snr_in >= snr_q);
      imp_allowed = IMPULSE_SCALE_TOP - {1'b0, imp_q};
      imp_ok = (imp_q == 4'h0)
               || (cand_impulses_in <= imp_allowed);
      nxt_state.accept = cand_valid_in && strength_ok && snr_ok && imp_ok;
      nxt_state.reject = cand_valid_in
                         && !(strength_ok && snr_ok && imp_ok);

      // volume attenuation in dB, code 1 is -28 and 15 is 0 in the normal range, each 30 dB more in the low volume range
      if (vol == 4'h0)
      begin
         nxt_state.atten = 6'h00;
      end
      else
      begin
         nxt_state.atten = 6'(6'h1E - 6'({vol, 1'b0}));
         if (state_ff.cfg_sq[LOW_VOLUME_RANGE_BIT])
         begin
            nxt_state.atten = 6'(nxt_state.atten
                              + LOW_RANGE_EXTRA_DB);
         end
      end

      // softmute depth 16 dB minus two per code step
      nxt_state.depth = 5'(5'h10 - 5'({state_ff.cfg_sq
                        [SOFTMUTE_DEPTH_LSB +: 2], 1'b0}));

      // power pins pass two flip-flops
      nxt_state.pd_meta = powered_down_in;
      nxt_state.pd_sync = state_ff.pd_meta;
      nxt_state.vio_meta = io_supply_ok_in;
      nxt_state.vio_sync = state_ff.vio_meta;
      nxt_state.hiz = state_ff.cfg_osc[AUDIO_HIZ_ENABLE_BIT]
                      && state_ff.pd_sync
                      && state_ff.vio_sync;
   end

   // ***************************************
   // registers
   // ***************************************
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         state_ff <= '0;
         state_ff.cfg_sbv <= SEEK_BAND_VOLUME_CONFIG_RST;
         state_ff.cfg_sq <= SOFTMUTE_SEEK_QUALITY_CONFIG_RST;
         state_ff.cfg_osc <= OSCILLATOR_AUDIO_HIZ_CONFIG_RST;
         state_ff.freq <= BASE_87M5_KHZ;
         state_ff.freq_valid <= 1'b1;
         state_ff.depth <= 5'h10;
         state_ff.mute <= 1'b1;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // ***************************************
   // outputs
   // ***************************************
   assign reg_rdata_out = state_ff.rdata;
   assign tuned_freq_khz_out = state_ff.freq;
   assign tuned_freq_valid_out = state_ff.freq_valid;
   assign cand_accept_out = state_ff.accept;
   assign cand_reject_out = state_ff.reject;
   assign audio_mute_out = state_ff.mute;
   assign volume_code_out = state_ff.cfg_sbv[VOLUME_LSB +: 4];
   assign low_volume_range_out = state_ff.cfg_sq[LOW_VOLUME_RANGE_BIT];
   assign volume_atten_db_out = state_ff.atten;
   assign softmute_rate_out =
      state_ff.cfg_sq[SOFTMUTE_RATE_LSB +: 2];
   assign softmute_depth_db_out = state_ff.depth;
   assign crystal_osc_enable_out = state_ff.cfg_osc[CRYSTAL_OSC_ENABLE_BIT];
   assign audio_hiz_active_out = state_ff.hiz;

endmodule

// >>> shared/tsa_pkg.sv
// constants for the tuner seek and audio configuration register bank
package tsa_pkg;

   // ***************************************
   // register indices and reset values
   // ***************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [7:0] SEEK_BAND_VOLUME_CONFIG_IDX = 8'h05;
   localparam logic [7:0] SOFTMUTE_SEEK_QUALITY_CONFIG_IDX = 8'h06;
   localparam logic [7:0] OSCILLATOR_AUDIO_HIZ_CONFIG_IDX = 8'h07;
   localparam logic [15:0] SEEK_BAND_VOLUME_CONFIG_RST = 16'h0000;
   localparam logic [15:0] SOFTMUTE_SEEK_QUALITY_CONFIG_RST = 16'h0000;
   localparam logic [15:0] OSCILLATOR_AUDIO_HIZ_CONFIG_RST = 16'h0100;

   // ***************************************
   // field positions
   // ***************************************
   localparam int SEEK_STRENGTH_FLOOR_LSB = 8;
   localparam int BAND_LSB = 6;
   localparam int STEP_LSB = 4;
   localparam int VOLUME_LSB = 0;
   localparam int SOFTMUTE_RATE_LSB = 14;
   localparam int SOFTMUTE_DEPTH_LSB = 12;
   localparam int RESERVED_CFG3_LSB = 9;
   localparam int LOW_VOLUME_RANGE_BIT = 8;
   localparam int SEEK_SNR_QUALIFIER_LSB = 4;
   localparam int SEEK_IMPULSE_LIMIT_LSB = 0;
   localparam int CRYSTAL_OSC_ENABLE_BIT = 15;
   localparam int AUDIO_HIZ_ENABLE_BIT = 14;

   // ***************************************
   // band and step encodings
   // ***************************************
   localparam logic [1:0] BAND_WIDE_EU = 2'h0;
   localparam logic [1:0] BAND_WIDE_JP = 2'h1;
   localparam logic [1:0] BAND_NARROW_JP = 2'h2;
   localparam logic [1:0] STEP_200K = 2'h0;
   localparam logic [1:0] STEP_100K = 2'h1;
   localparam logic [1:0] STEP_50K = 2'h2;
   localparam int FREQ_W = 19;
   localparam logic [18:0] BASE_87M5_KHZ = 19'h155CC;
   localparam logic [18:0] BASE_76M_KHZ = 19'h128E0;
   localparam logic [7:0] STEP_200_KHZ = 8'hC8;
   localparam logic [7:0] STEP_100_KHZ = 8'h64;
   localparam logic [7:0] STEP_50_KHZ = 8'h32;

   // ***************************************
   // volume and qualifier figures
   // ***************************************
   localparam logic [5:0] LOW_RANGE_EXTRA_DB = 6'h1E;
   localparam logic [4:0] IMPULSE_SCALE_TOP = 5'h10;

endpackage

// >>> test/tsa_config_regs_assertions.sv
// port assertions for the configuration bank
`timescale 1ns/1ps
module tsa_cfg_chk
   import tsa_pkg::*;
#(parameter int CHAN_W = 10)
(
   // watched ports
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [DATA_W-1:0] reg_rdata_out,
   input wire logic [CHAN_W-1:0] channel_in,
   input wire logic [FREQ_W-1:0] tuned_freq_khz_out,
   input wire logic cand_valid_in,
   input wire logic cand_accept_out,
   input wire logic cand_reject_out,
   input wire logic audio_mute_out,
   input wire logic [3:0] volume_code_out,
   input wire logic low_volume_range_out,
   input wire logic [5:0] volume_atten_db_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   sequence verdict_s;
      ##1 cand_accept_out ^ cand_reject_out;
   endsequence
   cand_verdict_a: assert property (cand_valid_in |-> verdict_s)
      else $error("candidate got no single verdict");
   cand_idle_a:
      assert property (!cand_valid_in |=> !cand_accept_out && !cand_reject_out)
      else $error("verdict without candidate");
   mute_flag_a:
      assert property (audio_mute_out == (volume_code_out == 4'h0))
      else $error("mute flag wrong");
   atten_value_a:
      assert property (1'b1 |=> volume_atten_db_out == ($past(audio_mute_out)
         ? 6'h00 : 6'h1E - {$past(volume_code_out), 1'b0}
         + ($past(low_volume_range_out) ? 6'h1E : 6'h00)))
      else $error("attenuation wrong");
   atten_cause_a:
      assert property ($changed(volume_atten_db_out) |-> $past(reg_wr_in, 2))
      else $error("attenuation moved without a write");
   freq_cause_a:
      assert property ($changed(tuned_freq_khz_out) |-> $past(reg_wr_in, 2)
         || $past(channel_in) != $past(channel_in, 2))
      else $error("frequency moved without cause");
   rdata_idle_a:
      assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
      else $error("read data outside answer cycle");
endmodule
bind tsa_config_regs tsa_cfg_chk #(.CHAN_W(CHAN_W)) chk_i (
   .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .channel_in(channel_in), .tuned_freq_khz_out(tuned_freq_khz_out),
   .cand_valid_in(cand_valid_in), .cand_accept_out(cand_accept_out),
   .cand_reject_out(cand_reject_out), .audio_mute_out(audio_mute_out),
   .volume_code_out(volume_code_out),
   .low_volume_range_out(low_volume_range_out),
   .volume_atten_db_out(volume_atten_db_out)
);

// >>> test/testbench.sv
// random and corner tests for the configuration bank
`timescale 1ns/1ps
module testbench
   import tsa_pkg::*;
();
   logic clk, rst, wr, rd, cv, pd, vio, fv, acc, rej, mute, lvr, osc, hiz, e;
   logic [7:0] addr, cs;
   logic [15:0] wd, rdat, w5, w6, w7;
   logic [9:0] ch;
   logic [3:0] cn, vol;
   logic [4:0] ci, dep;
   logic [5:0] att;
   logic [1:0] rate;
   logic [18:0] freq;
   int n_mismatch = 0;
   int total_checks = 0;
   tsa_config_regs #(.CHAN_W(10)) uut (
      .core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr),
      .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdat), .channel_in(ch), .tuned_freq_khz_out(freq),
      .tuned_freq_valid_out(fv), .cand_valid_in(cv),
      .cand_strength_in(cs), .cand_snr_in(cn), .cand_impulses_in(ci),
      .cand_accept_out(acc), .cand_reject_out(rej),
      .audio_mute_out(mute), .volume_code_out(vol),
      .low_volume_range_out(lvr), .volume_atten_db_out(att),
      .softmute_rate_out(rate), .softmute_depth_db_out(dep),
      .powered_down_in(pd), .io_supply_ok_in(vio),
      .crystal_osc_enable_out(osc), .audio_hiz_active_out(hiz)
   );
   function automatic logic [18:0] f_freq(logic [1:0] b, s, logic [9:0] c);
      logic [18:0] st;
      st = s == STEP_200K ? 19'h000C8 : s == STEP_100K ? 19'h00064 : 19'h00032;
      return (b == BAND_WIDE_EU ? BASE_87M5_KHZ : BASE_76M_KHZ) + st * c;
   endfunction
   function automatic logic [5:0] f_att(logic [3:0] v, logic x);
      return v == 4'h0 ? 6'h00 : 6'h1E - {v, 1'b0} + (x ? 6'h1E : 6'h00);
   endfunction
   function automatic logic f_acc(logic [15:0] a, b, logic [7:0] s,
      logic [3:0] n, logic [4:0] i);
      return s >= a[15:8] && (b[7:4] == 4'h0 || n >= b[7:4])
         && (b[3:0] == 4'h0 || i <= 5'h10 - b[3:0]);
   endfunction
   task automatic chk(logic [18:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wr_reg(logic [7:0] a, logic [15:0] d);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_reg(logic [7:0] a, logic [15:0] x);
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdat, x);
      @(posedge clk);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      {rst, wr, rd, cv, pd, vio} = 6'h20;
      {addr, cs, cn, ci, wd, ch} = '0;
      void'($urandom(32'hCC53));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk(freq, BASE_87M5_KHZ);
      chk({fv, mute, att, dep, osc, hiz}, {2'h3, 6'h00, 5'h10, 2'h0});
      for (int a = 5; a < 9; a++)
      begin
         @(posedge clk);
         rd_reg(8'(a), a == 7 ? 16'h0100 : 16'h0000);
      end
      $display("reset test done");
      for (int i = 0; i < 24; i++)
      begin
         w5 = 16'($urandom);
         w6 = 16'($urandom) & 16'hF1FF;
         if (i < 4)
            w5[7:4] = {i[1:0], i[1:0]};
         if (i == 4)
            {w5[15:8], w5[3:0], w6[8:0]} = {8'h7F, 4'hF, 9'h17F};
         wr_reg(SEEK_BAND_VOLUME_CONFIG_IDX, w5);
         wr_reg(SOFTMUTE_SEEK_QUALITY_CONFIG_IDX, w6);
         wr_reg(8'h08, ~w5);
         ch <= 10'($urandom);
         rd_reg(SEEK_BAND_VOLUME_CONFIG_IDX, w5);
         rd_reg(SOFTMUTE_SEEK_QUALITY_CONFIG_IDX, w6);
         @(negedge clk);
         chk({vol, mute}, {w5[3:0], w5[3:0] == 4'h0});
         chk({lvr, att}, {w6[8], f_att(w5[3:0], w6[8])});
         chk(rate, w6[15:14]);
         chk(dep, 5'h10 - {w6[13:12], 1'b0});
         e = w5[7:6] != 2'h3 && w5[5:4] != 2'h3;
         chk(fv, e);
         if (e)
            chk(freq, f_freq(w5[7:6], w5[5:4], ch));
         @(posedge clk);
         cs <= w5[15:8] + 8'($urandom % 3) - 8'h01;
         cn <= 4'($urandom);
         ci <= 5'($urandom % 18);
         cv <= 1'b1;
         @(posedge clk);
         cv <= 1'b0;
         @(negedge clk);
         e = f_acc(w5, w6, cs, cn, ci);
         chk({acc, rej}, {e, !e});
         @(posedge clk);
      end
      $display("config test done");
      w7 = OSCILLATOR_AUDIO_HIZ_CONFIG_RST;
      for (int k = 0; k < 8; k++)
      begin
         rd_reg(OSCILLATOR_AUDIO_HIZ_CONFIG_IDX, w7);
         w7 = {1'b1, k[2], k[1] ? 14'h0100 : 14'h3C04};
         wr_reg(OSCILLATOR_AUDIO_HIZ_CONFIG_IDX, w7);
         pd <= k[1];
         vio <= k[0];
         wr <= 1'b0;
         repeat (4) @(posedge clk);
         @(negedge clk);
         chk({osc, hiz}, {1'b1, k[2] & k[1] & k[0]});
         @(posedge clk);
      end
      $display("oscillator test done");
      stop_test;
   end
endmodule
